// ---- dab_align_regs.vh ----
// Purpose: Constants shared by the data alignment block files.
// Assumes: Included by bare name; definitions only.
// Notes:   Byte 0 of a word sits in bits 63:56.
`ifndef DAB_ALIGN_REGS_VH
`define DAB_ALIGN_REGS_VH

// ****************************************
// Widths and depths
// ****************************************
`define DAB_WORD_W        64
`define DAB_LEN_W         12
`define DAB_FIFO_DEPTH    32
`define DAB_UNITS         3

// ****************************************
// Unit indices and copy source codes
// ****************************************
`define DAB_UNIT_CLS1     2'h0
`define DAB_UNIT_CLS2     2'h1
`define DAB_UNIT_CTRL     2'h2
`define DAB_COPY_CLS1     4'h8
`define DAB_COPY_CLS2     4'h9
`define DAB_COPY_CTRL     4'hA

// ****************************************
// Entry field encodings
// ****************************************
`define DAB_SRC_IQ        1'b0
`define DAB_SRC_AUX       1'b1
`define DAB_DEST_DED      1'b0
`define DAB_DEST_DMA      1'b1

// ****************************************
// Counts and reset values
// ****************************************
`define DAB_NIB_WORD      5'h10
`define DAB_CNT_FULL      6'h10
`define DAB_CNT_RST       6'h00
`define DAB_FULL_BYTES    4'h8

`endif

// ---- dab_align_top.v ----
// Purpose: Three byte-alignment units feeding accelerators, DMA and controller.
// Assumes: All inputs come from logic on ref_clk_in; no pin synchronisers.
// Notes:   Units work in nibbles; only the class-1 unit honours odd skips.
`timescale 1ns/1ps
`default_nettype none
`include "dab_align_regs.vh"

module dab_align_top #(
  parameter W      = `DAB_WORD_W,
  parameter LEN_W  = `DAB_LEN_W,
  parameter DEPTH  = `DAB_FIFO_DEPTH,
  parameter AW     = 5
) (
  input  wire              ref_clk_in,
  input  wire              rst_in,
  input  wire              ce_in,
  input  wire              iq_reset_in,
  input  wire [W-1:0]      iq_data_in,
  input  wire              iq_valid_in,
  output wire              iq_ready_out,
  input  wire [W-1:0]      aux_data_in,
  input  wire              aux_valid_in,
  output wire              aux_ready_out,
  input  wire              entry_valid_in,
  output wire              entry_ready_out,
  input  wire [1:0]        entry_unit_in,
  input  wire              entry_src_in,
  input  wire [LEN_W-1:0]  entry_len_in,
  input  wire [3:0]        entry_skip_in,
  input  wire              entry_flush_in,
  input  wire              entry_dest_in,
  input  wire [3:0]        dma_src_in,
  input  wire              dma_ready_in,
  output wire [W-1:0]      dma_data_out,
  output wire [3:0]        dma_bytes_out,
  output wire              dma_valid_out,
  input  wire              c1_ready_in,
  output wire [W-1:0]      c1_data_out,
  output wire [3:0]        c1_bytes_out,
  output wire              c1_valid_out,
  input  wire              c2_ready_in,
  output wire [W-1:0]      c2_data_out,
  output wire [3:0]        c2_bytes_out,
  output wire              c2_valid_out,
  input  wire              ctl_ready_in,
  output wire [W-1:0]      ctl_data_out,
  output wire [3:0]        ctl_bytes_out,
  output wire              ctl_valid_out
);

  // ****************************************
  // Unit states
  // ****************************************
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_MOVE  = 3'h2;
  localparam [2:0] ST_FLUSH = 3'h4;

  localparam NU = `DAB_UNITS;

  // ****************************************
  // Input queue buffer
  // ****************************************
  wire [W-1:0]   fq_data_w;
  wire           fq_valid_w;
  wire           fq_ready_w;

  // Queue reset or rst_in drains buffered input; no other exit exists
  dab_fifo #(
    .W     (W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_iq_fifo (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .ce_in        (ce_in),
    .clear_in     (iq_reset_in),
    .wr_data_in   (iq_data_in),
    .wr_valid_in  (iq_valid_in),
    .wr_ready_out (iq_ready_out),
    .rd_data_out  (fq_data_w),
    .rd_valid_out (fq_valid_w),
    .rd_ready_in  (fq_ready_w)
  );

  // ****************************************
  // Shared source arbitration
  // ****************************************
  wire [NU-1:0]   req_all;
  wire [NU-1:0]   src_all;
  wire [NU-1:0]   dest_all;
  wire [NU-1:0]   idle_all;
  wire [NU-1:0]   ov_all;
  wire [NU*W-1:0] ow_all;
  wire [NU*4-1:0] ob_all;
  wire [NU-1:0]   take_all;
  wire [NU-1:0]   ded_rdy;
  wire [NU-1:0]   dma_hit;
  wire [NU-1:0]   r_iq;
  wire [NU-1:0]   r_ax;
  wire [NU-1:0]   g_iq;
  wire [NU-1:0]   g_ax;

  // Identical sources for every unit; lowest index wins a clash
  assign r_iq = req_all & ~src_all;
  assign r_ax = req_all & src_all;
  assign g_iq = r_iq & (~r_iq + {{(NU-1){1'b0}}, 1'b1});
  assign g_ax = r_ax & (~r_ax + {{(NU-1){1'b0}}, 1'b1});

  assign fq_ready_w    = |g_iq;
  assign aux_ready_out = |g_ax;

  // ****************************************
  // Consumer selection
  // ****************************************
  assign ded_rdy = {ctl_ready_in, c2_ready_in, c1_ready_in};

  // Copy source code picks which unit the DMA drains
  assign dma_hit[0] = (dma_src_in == `DAB_COPY_CLS1);
  assign dma_hit[1] = (dma_src_in == `DAB_COPY_CLS2);
  assign dma_hit[2] = (dma_src_in == `DAB_COPY_CTRL);

  // Unknown unit codes are accepted and dropped so the queue never jams
  assign entry_ready_out = (entry_unit_in > `DAB_UNIT_CTRL) ? 1'b1 : idle_all[entry_unit_in];

  // ****************************************
  // Alignment units
  // ****************************************
  genvar u;
  generate
    for (u = 0; u < NU; u = u + 1) begin : g_unit
      reg  [2:0]       st_q;
      reg  [2:0]       st_d;
      reg  [2*W-1:0]   buf_q;
      reg  [2*W-1:0]   buf_d;
      reg  [5:0]       cnt_q;
      reg  [5:0]       cnt_d;
      reg  [LEN_W:0]   rem_q;
      reg  [LEN_W:0]   rem_d;
      reg  [3:0]       skip_q;
      reg  [3:0]       skip_d;
      reg              src_q;
      reg              flush_q;
      reg              dest_q;
      reg  [W-1:0]     ow_q;
      reg  [W-1:0]     ow_d;
      reg              ov_q;
      reg              ov_d;
      reg  [3:0]       ob_q;
      reg  [3:0]       ob_d;
      reg  [4:0]       avail;
      reg  [4:0]       take;
      reg  [W-1:0]     word;
      reg  [W-1:0]     vbits;
      reg  [W-1:0]     mask;
      wire             accept;
      wire             out_take;
      wire             room;
      wire             load_full;
      wire             load_part;
      wire             push;
      wire [3:0]       skip_in;

      // Half-byte skips only exist in the class-1 unit
      if (u == 0) begin : g_nib
        assign skip_in = entry_skip_in;
      end else begin : g_byte
        assign skip_in = {entry_skip_in[3:1], 1'b0};
      end

      // The only way in is an accepted info entry
      assign accept = entry_valid_in && (entry_unit_in == u) && (st_q == ST_IDLE) && !ov_q;

      // Output goes to the DMA or this unit's own consumer
      assign out_take = ov_q && ((dest_q == `DAB_DEST_DMA) ? (dma_ready_in && dma_hit[u]) : ded_rdy[u]);

      assign room      = !ov_q || out_take;
      assign load_full = room && (cnt_q >= `DAB_CNT_FULL);
      // Residue leaves early only in the flush state
      assign load_part = room && (st_q == ST_FLUSH) && (cnt_q != `DAB_CNT_RST)
                         && (cnt_q < `DAB_CNT_FULL);

      // Stall pushes while popping; trades throughput for a simple buffer
      assign req_all[u] = (st_q == ST_MOVE) && (rem_q != {(LEN_W+1){1'b0}})
                          && (cnt_q < `DAB_CNT_FULL) && !load_full;
      assign push       = (g_iq[u] && fq_valid_w) || (g_ax[u] && aux_valid_in);

      assign src_all[u]        = src_q;
      assign dest_all[u]       = dest_q;
      assign idle_all[u]       = (st_q == ST_IDLE) && !ov_q;
      assign ov_all[u]         = ov_q;
      assign ow_all[u*W +: W]  = ow_q;
      assign ob_all[u*4 +: 4]  = ob_q;
      assign take_all[u]       = out_take;

      always @* begin
        st_d   = st_q;
        buf_d  = buf_q;
        cnt_d  = cnt_q;
        rem_d  = rem_q;
        skip_d = skip_q;
        ow_d   = ow_q;
        ov_d   = ov_q && !out_take;
        ob_d   = ob_q;
        word   = (src_q == `DAB_SRC_AUX) ? aux_data_in : fq_data_w;
        avail  = `DAB_NIB_WORD - {1'b0, skip_q};
        take   = (rem_q < {{(LEN_W-4){1'b0}}, avail}) ? rem_q[4:0] : avail;
        // Drop skipped nibbles, keep only what the entry still wants
        vbits  = word << {skip_q, 2'b00};
        mask   = ~({W{1'b1}} >> {take, 2'b00});
        if (load_full) begin
          ow_d  = buf_q[2*W-1:W];
          ob_d  = `DAB_FULL_BYTES;
          ov_d  = 1'b1;
          buf_d = {buf_q[W-1:0], {W{1'b0}}};
          cnt_d = cnt_q - `DAB_CNT_FULL;
        end else if (load_part) begin
          ow_d  = buf_q[2*W-1:W];
          ob_d  = cnt_q[4:1] + {3'h0, cnt_q[0]};
          ov_d  = 1'b1;
          buf_d = {(2*W){1'b0}};
          cnt_d = `DAB_CNT_RST;
        end else if (push) begin
          // Append after the residue so words come out concatenated
          buf_d  = buf_q | ({vbits & mask, {W{1'b0}}} >> {cnt_q, 2'b00});
          cnt_d  = cnt_q + {1'b0, take};
          rem_d  = rem_q - {{(LEN_W-4){1'b0}}, take};
          skip_d = 4'h0;
        end
        case (st_q)
          ST_IDLE: begin
            if (accept) begin
              st_d   = ST_MOVE;
              rem_d  = {entry_len_in, 1'b0};
              skip_d = skip_in;
            end
          end
          ST_MOVE: begin
            // Without flush the residue waits to join the next entry
            if (rem_q == {(LEN_W+1){1'b0}}) begin
              st_d = flush_q ? ST_FLUSH : ST_IDLE;
            end
          end
          ST_FLUSH: begin
            if (cnt_q == `DAB_CNT_RST) begin
              st_d = ST_IDLE;
            end
          end
          default: begin
            st_d = ST_IDLE;
          end
        endcase
      end

      always @(posedge ref_clk_in) begin
        if (rst_in || (ce_in && iq_reset_in)) begin
          st_q    <= ST_IDLE;
          buf_q   <= {(2*W){1'b0}};
          cnt_q   <= `DAB_CNT_RST;
          rem_q   <= {(LEN_W+1){1'b0}};
          skip_q  <= 4'h0;
          src_q   <= `DAB_SRC_IQ;
          flush_q <= 1'b0;
          dest_q  <= `DAB_DEST_DED;
          ow_q    <= {W{1'b0}};
          ov_q    <= 1'b0;
          ob_q    <= 4'h0;
        end else if (ce_in) begin
          st_q   <= st_d;
          buf_q  <= buf_d;
          cnt_q  <= cnt_d;
          rem_q  <= rem_d;
          skip_q <= skip_d;
          ow_q   <= ow_d;
          ov_q   <= ov_d;
          ob_q   <= ob_d;
          if (accept) begin
            src_q   <= entry_src_in;
            flush_q <= entry_flush_in;
            dest_q  <= entry_dest_in;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // DMA port
  // ****************************************
  reg  [W-1:0]  dma_data_r;
  reg  [3:0]    dma_bytes_r;
  reg           dma_valid_r;
  integer       k;

  // Mux of unit output flops; no extra stage to keep latency at zero
  always @* begin
    dma_data_r  = {W{1'b0}};
    dma_bytes_r = 4'h0;
    dma_valid_r = 1'b0;
    for (k = 0; k < NU; k = k + 1) begin
      if (dma_hit[k] && ov_all[k] && (dest_all[k] == `DAB_DEST_DMA)) begin
        dma_data_r  = ow_all[k*W +: W];
        dma_bytes_r = ob_all[k*4 +: 4];
        dma_valid_r = 1'b1;
      end
    end
  end

  assign dma_data_out  = dma_data_r;
  assign dma_bytes_out = dma_bytes_r;
  assign dma_valid_out = dma_valid_r;

  // ****************************************
  // Dedicated consumers
  // ****************************************
  // Accelerators see nothing that bypassed their own unit
  assign c1_data_out   = ow_all[0*W +: W];
  assign c1_bytes_out  = ob_all[3:0];
  assign c1_valid_out  = ov_all[0] && (dest_all[0] == `DAB_DEST_DED);
  assign c2_data_out   = ow_all[1*W +: W];
  assign c2_bytes_out  = ob_all[7:4];
  assign c2_valid_out  = ov_all[1] && (dest_all[1] == `DAB_DEST_DED);

  // Controller port doubles as the arithmetic operand source
  assign ctl_data_out  = ow_all[2*W +: W];
  assign ctl_bytes_out = ob_all[11:8];
  assign ctl_valid_out = ov_all[2] && (dest_all[2] == `DAB_DEST_DED);

endmodule // dab_align_top

`default_nettype wire

// ---- dab_align_top_monitor.sv ----
// Purpose: Port assertions for the alignment top.
// Assumes: One clock; rst_in synchronous, active high.
// Notes:   ce_in low freezes state, so holds are gated by it.
`timescale 1ns/1ps
`default_nettype none
module dab_align_top_monitor #(parameter W = 64) (
  input wire logic         ref_clk_in,
  input wire logic         rst_in,
  input wire logic         ce_in,
  input wire logic         iq_reset_in,
  input wire logic         iq_ready_out,
  input wire logic         aux_ready_out,
  input wire logic         entry_valid_in,
  input wire logic         entry_ready_out,
  input wire logic [3:0]   dma_src_in,
  input wire logic         dma_ready_in,
  input wire logic [W-1:0] dma_data_out,
  input wire logic [3:0]   dma_bytes_out,
  input wire logic         dma_valid_out,
  input wire logic         c1_ready_in,
  input wire logic [W-1:0] c1_data_out,
  input wire logic [3:0]   c1_bytes_out,
  input wire logic         c1_valid_out,
  input wire logic         c2_ready_in,
  input wire logic [W-1:0] c2_data_out,
  input wire logic [3:0]   c2_bytes_out,
  input wire logic         c2_valid_out,
  input wire logic [W-1:0] ctl_data_out,
  input wire logic [3:0]   ctl_bytes_out,
  input wire logic         ctl_valid_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  logic idle_q;
  // Only an accepted entry may wake a unit; either reset rearms
  always @(posedge ref_clk_in) begin
    if (rst_in || (ce_in && iq_reset_in)) idle_q <= 1'b1;
    else if (ce_in && entry_valid_in && entry_ready_out) idle_q <= 1'b0;
  end
  a_reset_quiet: assert property (!rst_in && $past(rst_in) |-> entry_ready_out && iq_ready_out &&
    !aux_ready_out && !c1_valid_out && !c2_valid_out && !ctl_valid_out && !dma_valid_out) else $error("reset not quiet");
  a_iq_clear: assert property (ce_in && iq_reset_in |=> iq_ready_out && !c1_valid_out &&
    !c2_valid_out && !ctl_valid_out && !dma_valid_out) else $error("queue reset not clearing");
  a_c1_hold: assert property (ce_in && !iq_reset_in && c1_valid_out && !c1_ready_in |=>
    c1_valid_out && $stable(c1_data_out) && $stable(c1_bytes_out)) else $error("class1 word dropped");
  a_c2_hold: assert property (ce_in && !iq_reset_in && c2_valid_out && !c2_ready_in |=>
    c2_valid_out && $stable(c2_data_out) && $stable(c2_bytes_out)) else $error("class2 word dropped");
  a_bytes_range: assert property ((c1_valid_out || c2_valid_out || ctl_valid_out) |->
    (!c1_valid_out || c1_bytes_out inside {[4'h1:4'h8]}) && (!c2_valid_out || c2_bytes_out inside {[4'h1:4'h8]})
    && (!ctl_valid_out || ctl_bytes_out inside {[4'h1:4'h8]})) else $error("byte count out of range");
  a_dma_mux: assert property (dma_valid_out |-> {dma_bytes_out, dma_data_out} ==
    (dma_src_in == 4'h8 ? {c1_bytes_out, c1_data_out} : dma_src_in == 4'h9 ? {c2_bytes_out, c2_data_out}
    : {ctl_bytes_out, ctl_data_out})) else $error("copy source mux wrong");
  a_dma_only: assert property (dma_valid_out |-> (dma_src_in == 4'h8 && !c1_valid_out) ||
    (dma_src_in == 4'h9 && !c2_valid_out) || (dma_src_in == 4'hA && !ctl_valid_out)) else $error("two consumers");
  a_no_entry: assert property (idle_q |-> !aux_ready_out && !c1_valid_out && !c2_valid_out &&
    !ctl_valid_out && !dma_valid_out) else $error("unit active without entry");
  c_c1_full: cover property (c1_valid_out && c1_ready_in && c1_bytes_out == 4'h8);
  c_dma_part: cover property (dma_valid_out && dma_ready_in && dma_bytes_out < 4'h8);
  c_iq_full: cover property (!iq_ready_out);
endmodule // dab_align_top_monitor

bind dab_align_top dab_align_top_monitor #(.W(W)) u_mon (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .ce_in(ce_in), .iq_reset_in(iq_reset_in), .iq_ready_out(iq_ready_out), .aux_ready_out(aux_ready_out),
  .entry_valid_in(entry_valid_in), .entry_ready_out(entry_ready_out), .dma_src_in(dma_src_in),
  .dma_ready_in(dma_ready_in), .dma_data_out(dma_data_out), .dma_bytes_out(dma_bytes_out),
  .dma_valid_out(dma_valid_out), .c1_ready_in(c1_ready_in), .c1_data_out(c1_data_out),
  .c1_bytes_out(c1_bytes_out), .c1_valid_out(c1_valid_out), .c2_ready_in(c2_ready_in),
  .c2_data_out(c2_data_out), .c2_bytes_out(c2_bytes_out), .c2_valid_out(c2_valid_out),
  .ctl_data_out(ctl_data_out), .ctl_bytes_out(ctl_bytes_out), .ctl_valid_out(ctl_valid_out));
`default_nettype wire

// ---- dab_align_top_tb_top.sv ----
// Purpose: Self-checking bench for the alignment top.
// Assumes: Inputs change on the falling clock edge.
// Notes:   One queue collects every consumer handoff.
`timescale 1ns/1ps
`default_nettype none
module dab_align_top_tb_top;
  logic        ref_clk_in, rst_in, iq_reset_in, iq_valid_in, aux_valid_in, stall, ce;
  logic        entry_valid_in, entry_src_in, entry_flush_in, entry_dest_in;
  logic [63:0] iq_data_in, aux_data_in;
  logic [1:0]  entry_unit_in;
  logic [11:0] entry_len_in;
  logic [3:0]  entry_skip_in, dma_src_in;
  wire         iq_ready_out, aux_ready_out, entry_ready_out, dma_valid_out, c1_valid_out, c2_valid_out;
  wire         ctl_valid_out, dma_ready_in, c1_ready_in, c2_ready_in, ctl_ready_in;
  wire  [63:0] dma_data_out, c1_data_out, c2_data_out, ctl_data_out;
  wire  [3:0]  dma_bytes_out, c1_bytes_out, c2_bytes_out, ctl_bytes_out;
  logic [69:0] got[$];
  int          n_errors, checks_done;
  localparam logic [63:0] A = 64'h0123456789ABCDEF;
  localparam logic [63:0] B = 64'hFEDCBA9876543210;
  localparam logic [63:0] C = 64'h5A5A5A5AC3C3C3C3;
  dab_align_top uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce), .iq_reset_in(iq_reset_in),
    .iq_data_in(iq_data_in), .iq_valid_in(iq_valid_in), .iq_ready_out(iq_ready_out), .aux_data_in(aux_data_in),
    .aux_valid_in(aux_valid_in), .aux_ready_out(aux_ready_out), .entry_valid_in(entry_valid_in),
    .entry_ready_out(entry_ready_out), .entry_unit_in(entry_unit_in), .entry_src_in(entry_src_in),
    .entry_len_in(entry_len_in), .entry_skip_in(entry_skip_in), .entry_flush_in(entry_flush_in),
    .entry_dest_in(entry_dest_in), .dma_src_in(dma_src_in), .dma_ready_in(dma_ready_in),
    .dma_data_out(dma_data_out), .dma_bytes_out(dma_bytes_out), .dma_valid_out(dma_valid_out),
    .c1_ready_in(c1_ready_in), .c1_data_out(c1_data_out), .c1_bytes_out(c1_bytes_out),
    .c1_valid_out(c1_valid_out), .c2_ready_in(c2_ready_in), .c2_data_out(c2_data_out),
    .c2_bytes_out(c2_bytes_out), .c2_valid_out(c2_valid_out), .ctl_ready_in(ctl_ready_in),
    .ctl_data_out(ctl_data_out), .ctl_bytes_out(ctl_bytes_out), .ctl_valid_out(ctl_valid_out));
  dab_cons_model u_cons (.ref_clk_in(ref_clk_in), .stall_in(stall), .c1_ready_out(c1_ready_in),
    .c2_ready_out(c2_ready_in), .ctl_ready_out(ctl_ready_in), .dma_ready_out(dma_ready_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    if (ce && c1_valid_out && c1_ready_in) got.push_back({2'h0, c1_bytes_out, c1_data_out});
    if (ce && c2_valid_out && c2_ready_in) got.push_back({2'h1, c2_bytes_out, c2_data_out});
    if (ce && ctl_valid_out && ctl_ready_in) got.push_back({2'h2, ctl_bytes_out, ctl_data_out});
    if (ce && dma_valid_out && dma_ready_in) got.push_back({2'h3, dma_bytes_out, dma_data_out});
  end
  // ****
  // Tasks
  // ****
  task automatic complete_run();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [69:0] exp, input logic [69:0] act);
    checks_done++;
    if (act !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  // Hold the request until ready is seen at a rising edge
  task automatic hs(input int k);
    int i;
    logic ok;
    for (i = 0; i < 500; i++) begin
      // Let ready settle after the request was just driven
      #1;
      ok = (k == 0) ? iq_ready_out : (k == 1) ? aux_ready_out : entry_ready_out;
      @(posedge ref_clk_in);
      if (ok === 1'b1) return;
      @(negedge ref_clk_in);
    end
    n_errors++;
    complete_run();
  endtask
  task automatic push(input logic aux, input logic [63:0] d);
    @(negedge ref_clk_in);
    if (aux) aux_data_in = d;
    else iq_data_in = d;
    aux_valid_in = aux;
    iq_valid_in = !aux;
    hs(aux ? 1 : 0);
    @(negedge ref_clk_in);
    aux_valid_in = 1'b0;
    iq_valid_in = 1'b0;
    aux_data_in = ~d;
    iq_data_in = ~d;
  endtask
  task automatic send(input logic [1:0] u, input logic s, input logic [11:0] n, input logic [3:0] sk,
                      input logic fl, input logic de);
    @(negedge ref_clk_in);
    entry_valid_in = 1'b1;
    entry_unit_in = u;
    entry_src_in = s;
    entry_len_in = n;
    entry_skip_in = sk;
    entry_flush_in = fl;
    entry_dest_in = de;
    hs(2);
    @(negedge ref_clk_in);
    entry_valid_in = 1'b0;
  endtask
  task automatic expect_out(input logic [69:0] exp);
    int i;
    for (i = 0; i < 400 && got.size() == 0; i++) @(negedge ref_clk_in);
    if (got.size() == 0) begin
      n_errors++;
      complete_run();
    end else begin
      chk(exp, got.pop_front());
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_fill();
    int i;
    for (i = 0; i < 32; i++) push(1'b0, {32'hA5C30000 + i, ~i});
    @(negedge ref_clk_in);
    chk(70'h0, {68'h0, iq_ready_out, got.size() != 0});
    stall = 1'b1;
    send(2'h0, 1'b0, 12'h100, 4'h0, 1'b1, 1'b0);
    // Frozen clock enable: no pop, no word out
    ce = 1'b0;
    repeat (12) @(negedge ref_clk_in);
    chk(70'h0, {67'h0, iq_ready_out, c1_valid_out, got.size() != 0});
    ce = 1'b1;
    for (i = 0; i < 32; i++) expect_out({2'h0, 4'h8, 32'hA5C30000 + i, ~i});
    stall = 1'b0;
  endtask
  task automatic t_case(input logic [1:0] u, input logic [3:0] sk, input logic [11:0] n, input int nw,
                        input logic [69:0] exp);
    push(1'b0, A);
    if (nw > 1) push(1'b0, B);
    send(u, 1'b0, n, sk, 1'b1, 1'b0);
    expect_out(exp);
  endtask
  // Without flush the tail waits and heads the next entry
  task automatic t_pair();
    push(1'b0, A);
    send(2'h1, 1'b0, 12'h003, 4'h0, 1'b0, 1'b0);
    // Unit code 3 is taken and dropped
    send(2'h3, 1'b0, 12'h008, 4'h0, 1'b1, 1'b0);
    repeat (20) @(negedge ref_clk_in);
    chk(70'h0, {69'h0, got.size() != 0});
    push(1'b0, B);
    send(2'h1, 1'b0, 12'h005, 4'h0, 1'b1, 1'b0);
    expect_out({2'h1, 4'h8, A[63:40], B[63:24]});
  endtask
  task automatic t_copy();
    int u;
    logic [63:0] d;
    for (u = 0; u < 3; u++) begin
      d = C ^ {u[7:0], 56'h0};
      @(negedge ref_clk_in);
      dma_src_in = 4'h8 + u[3:0];
      send(u[1:0], 1'b1, 12'h005, 4'h0, 1'b1, 1'b1);
      push(1'b1, d);
      expect_out({2'h3, 4'h5, d[63:24], 24'h0});
    end
  endtask
  // Busy unit plus a stale queue word, then a clear
  task automatic t_clear(input logic core);
    send(2'h1, 1'b1, 12'h010, 4'h0, 1'b1, 1'b0);
    push(1'b1, A);
    push(1'b0, C);
    expect_out({2'h1, 4'h8, A});
    @(negedge ref_clk_in);
    if (core) rst_in = 1'b1;
    else iq_reset_in = 1'b1;
    @(negedge ref_clk_in);
    rst_in = 1'b0;
    iq_reset_in = 1'b0;
    chk({67'h0, 3'h6}, {67'h0, entry_ready_out, iq_ready_out, c2_valid_out});
    push(1'b0, B);
    send(2'h1, 1'b0, 12'h008, 4'h0, 1'b1, 1'b0);
    expect_out({2'h1, 4'h8, B});
  endtask
  // ****
  // Main
  // ****
  initial begin
    rst_in = 1'b1;
    iq_reset_in = 1'b0;
    iq_valid_in = 1'b0;
    aux_valid_in = 1'b0;
    stall = 1'b0;
    ce = 1'b1;
    entry_valid_in = 1'b0;
    entry_src_in = 1'b0;
    entry_flush_in = 1'b0;
    entry_dest_in = 1'b0;
    iq_data_in = 64'h0;
    aux_data_in = 64'h0;
    entry_unit_in = 2'h0;
    entry_len_in = 12'h0;
    entry_skip_in = 4'h0;
    dma_src_in = 4'h0;
    repeat (8) @(negedge ref_clk_in);
    rst_in = 1'b0;
    chk({63'h0, 7'h60}, {63'h0, entry_ready_out, iq_ready_out, aux_ready_out, c1_valid_out, c2_valid_out,
        ctl_valid_out, dma_valid_out});
    t_fill();
    t_case(2'h1, 4'h3, 12'h008, 2, {2'h1, 4'h8, A[55:0], B[63:56]});
    t_case(2'h0, 4'h1, 12'h008, 2, {2'h0, 4'h8, A[59:0], B[63:60]});
    t_case(2'h0, 4'h1, 12'h003, 1, {2'h0, 4'h3, A[59:36], 40'h0});
    t_case(2'h2, 4'h2, 12'h007, 1, {2'h2, 4'h7, A[55:0], 8'h0});
    t_pair();
    t_copy();
    t_clear(1'b0);
    t_clear(1'b1);
    complete_run();
  end
endmodule // dab_align_top_tb_top
`default_nettype wire

// ---- dab_cons_model.sv ----
// Purpose: Consumer side: accelerators, DMA and controller ready lines.
// Assumes: Ready changes only on the falling edge.
// Notes:   Stall mode grants one cycle in four.
`timescale 1ns/1ps
`default_nettype none
module dab_cons_model (
  input  wire logic ref_clk_in,
  input  wire logic stall_in,
  output logic      c1_ready_out,
  output logic      c2_ready_out,
  output logic      ctl_ready_out,
  output logic      dma_ready_out
);
  logic [1:0] cnt_q = 2'h0;
  always @(negedge ref_clk_in) begin
    cnt_q <= cnt_q + 2'h1;
  end
  // Slow takers stretch every hold
  assign c1_ready_out  = !stall_in || (cnt_q == 2'h0);
  assign c2_ready_out  = !stall_in || (cnt_q == 2'h1);
  assign ctl_ready_out = !stall_in || (cnt_q == 2'h2);
  assign dma_ready_out = !stall_in || (cnt_q == 2'h3);
endmodule // dab_cons_model
`default_nettype wire

// ---- dab_fifo.v ----
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock; clear_in empties it in one cycle.
// Notes:   Full and empty come from pointer compare, no look-ahead.
`timescale 1ns/1ps
`default_nettype none

module dab_fifo #(
  parameter W     = 64,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire           ref_clk_in,
  input  wire           rst_in,
  input  wire           ce_in,
  input  wire           clear_in,
  input  wire [W-1:0]   wr_data_in,
  input  wire           wr_valid_in,
  output wire           wr_ready_out,
  output wire [W-1:0]   rd_data_out,
  output wire           rd_valid_out,
  input  wire           rd_ready_in
);

  reg  [W-1:0]  mem [0:DEPTH-1];
  reg  [AW:0]   wp_q;
  reg  [AW:0]   rp_q;
  wire          empty_w;
  wire          full_w;
  wire          wr_w;
  wire          rd_w;

  assign empty_w      = (wp_q == rp_q);
  assign full_w       = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign wr_ready_out = !full_w;
  assign rd_valid_out = !empty_w;
  assign rd_data_out  = mem[rp_q[AW-1:0]];
  assign wr_w         = wr_valid_in && !full_w;
  assign rd_w         = rd_ready_in && !empty_w;

  always @(posedge ref_clk_in) begin
    if (ce_in && wr_w) begin
      mem[wp_q[AW-1:0]] <= wr_data_in;
    end
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else if (ce_in) begin
      if (clear_in) begin
        wp_q <= {(AW+1){1'b0}};
        rp_q <= {(AW+1){1'b0}};
      end else begin
        if (wr_w) begin
          wp_q <= wp_q + {{AW{1'b0}}, 1'b1};
        end
        if (rd_w) begin
          rp_q <= rp_q + {{AW{1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // dab_fifo

`default_nettype wire
